//--- pkg/buck_ctrl_regs.svh
// register offsets, field positions, reset values and constants
// assumes: included by bare name wherever a number is needed
`ifndef BUCK_CTRL_REGS_SVH
`define BUCK_CTRL_REGS_SVH

`define REG_STATUS       8'h00
`define REG_SWITCH       8'h01
`define REG_TIMING_LO    8'h02
`define REG_TIMING_HI    8'h03
`define REG_FINE_TRIM    8'h04
`define REG_MARGIN       8'h06
`define REG_RESET_VAL    8'h00
`define REG_COUNT        6
`define REG_NONE         3'h7

`define ULTRA_BIT        5
`define PSV_MSB          1
`define PSV_ULTRASONIC   2'h2
`define TRIM_MSB         4
`define MARGIN_MSB       2

`define TARGET_ADDR_HI   4'h1
`define DIR_READ         1'b1

`define TRIM_ZERO_CODE   6'h10
`define TRIM_LIMIT       6'sh0c
`define MARGIN_DN10      3'h1
`define MARGIN_DN5       3'h2
`define MARGIN_UP5       3'h5
`define MARGIN_UP10      3'h6

`define ULTRA_STEP_HZ    15'h186a
`define MARGIN_BASE      11'sh0c8
`define MARGIN_UNIT      11'sh00a
`define TRIM_BASE        11'sh190
`define TRIM_UNIT        11'sh003

`endif

//--- pkg/buck_ctrl_pkg.sv
// types and shared decode for the serial register port
// assumes: buck_ctrl_regs.svh on the include path
`include "buck_ctrl_regs.svh"

package buck_ctrl_pkg;

	typedef enum
	{
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_PTR,
		ST_PTR_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RACK
	} port_state_type;

	typedef logic [7:0] reg_byte_type;

	// pointer to storage slot; unmapped pointers give REG_NONE
	function automatic logic [2:0] reg_index(input logic [7:0] ptr);
		case (ptr)
			`REG_STATUS:    return 3'h0;
			`REG_SWITCH:    return 3'h1;
			`REG_TIMING_LO: return 3'h2;
			`REG_TIMING_HI: return 3'h3;
			`REG_FINE_TRIM: return 3'h4;
			`REG_MARGIN:    return 3'h5;
			default:        return `REG_NONE;
		endcase
	endfunction

endpackage

//--- pkg/pin_event_if.sv
// synchronised bus line levels and conditions, one cycle pulses
// assumes: producer and consumer share sys_clk
`timescale 1ns/100ps
`default_nettype none

interface pin_event_if;
	logic scl_rise;
	logic scl_fall;
	logic sda_level;
	logic start_cond;
	logic stop_cond;

	modport producer (output scl_rise, scl_fall, sda_level, start_cond, stop_cond);
	modport consumer (input scl_rise, scl_fall, sda_level, start_cond, stop_cond);
endinterface

`default_nettype wire

//--- pkg/reg_access_if.sv
// register bank access: registered read, single write strobe
// assumes: one clock shared by engine and bank
`timescale 1ns/100ps
`default_nettype none

interface reg_access_if;
	import buck_ctrl_pkg::*;
	logic [7:0]   rd_ptr;
	reg_byte_type rd_data;
	logic         wr_en;
	logic [7:0]   wr_ptr;
	reg_byte_type wr_data;
	reg_byte_type timing_lo;
	reg_byte_type timing_hi;
	reg_byte_type fine_trim;
	reg_byte_type margin;

	modport engine (output rd_ptr, wr_en, wr_ptr, wr_data,
		input rd_data, timing_lo, timing_hi, fine_trim, margin);
	modport bank (input rd_ptr, wr_en, wr_ptr, wr_data,
		output rd_data, timing_lo, timing_hi, fine_trim, margin);
endinterface

`default_nettype wire

//--- rtl/i2c_pin_sync.sv
// two-stage synchronisers for bus lines and straps, condition detect
// assumes: lines idle high; straps static in operation
`timescale 1ns/100ps
`default_nettype none

module i2c_pin_sync
	import buck_ctrl_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	input  wire logic [2:0]  strap_in,
	output logic      [2:0]  strap_sync,
	pin_event_if.producer    ev
);

	logic       scl_m_r;
	logic       scl_s_r;
	logic       scl_d_r;
	logic       sda_m_r;
	logic       sda_s_r;
	logic       sda_d_r;
	logic [2:0] strap_m_r;
	logic [2:0] strap_s_r;

	// first stage feeds only the second; 40 MHz leaves margin at fast mode
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_m_r <= scl_in;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			strap_m_r <= 3'h0;
			strap_s_r <= 3'h0;
		end
		else
		begin
			strap_m_r <= strap_in;
			strap_s_r <= strap_m_r;
		end
	end

	assign strap_sync   = strap_s_r;
	assign ev.scl_rise  = scl_s_r & ~scl_d_r;
	assign ev.scl_fall  = ~scl_s_r & scl_d_r;
	assign ev.sda_level = sda_s_r;
	assign ev.start_cond = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	assign ev.stop_cond  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

endmodule

`default_nettype wire

//--- rtl/reg_bank.sv
// six byte registers with registered read port
// assumes: one write strobe per byte, pointer stable between accesses
`timescale 1ns/100ps
`default_nettype none
`include "buck_ctrl_regs.svh"

module reg_bank
	import buck_ctrl_pkg::*;
(
	input  wire logic     sys_clk,
	input  wire logic     rst_n,
	reg_access_if.bank    acc
);

	reg_byte_type mem_r [`REG_COUNT];
	reg_byte_type rd_data_r;
	logic [2:0]   wr_idx;
	logic [2:0]   rd_idx;

	assign wr_idx = reg_index(acc.wr_ptr);
	assign rd_idx = reg_index(acc.rd_ptr);

	// unmapped pointers swallow writes
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < `REG_COUNT; i++)
				mem_r[i] <= `REG_RESET_VAL;
		end
		else if (acc.wr_en && wr_idx != `REG_NONE)
		begin
			mem_r[wr_idx] <= acc.wr_data;
		end
	end

	// unmapped pointers read as zero
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			rd_data_r <= `REG_RESET_VAL;
		else if (rd_idx == `REG_NONE)
			rd_data_r <= 8'h00;
		else
			rd_data_r <= mem_r[rd_idx];
	end

	assign acc.rd_data   = rd_data_r;
	assign acc.timing_lo = mem_r[reg_index(`REG_TIMING_LO)];
	assign acc.timing_hi = mem_r[reg_index(`REG_TIMING_HI)];
	assign acc.fine_trim = mem_r[reg_index(`REG_FINE_TRIM)];
	assign acc.margin    = mem_r[reg_index(`REG_MARGIN)];

endmodule

`default_nettype wire

//--- rtl/buck_ctrl_i2c_reg_port.sv
// serial register port of a buck controller: bus target plus field decode
// assumes: open-drain bus resolved outside; lines well slower than sys_clk
//
// What this block does
// - ultrasonic minimum frequency from split two-bit field
// - margin codes give minus/plus five or ten
// - fine trim five bits, 0.75 steps, saturating
// - margin and trim combine by multiplication
// - six eight-bit registers, read and write
// - seven-bit addressing only, no ten-bit
// - standard or fast mode bus rate
// - address is 0001 plus three strap pins
// - direction bit zero writes, one reads
// - write: address, pointer, data, each acknowledged
// - combined read returns pointed byte after restart
// - pointer kept across unrelated bus traffic
// - no pointer increment; one register per transaction
// - repeated start accepted at any boundary
`timescale 1ns/100ps
`default_nettype none
`include "buck_ctrl_regs.svh"

module buck_ctrl_i2c_reg_port
	import buck_ctrl_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic [2:0]  address_strap_pins,
	output logic      [1:0]  ultra_min_freq_code,
	output logic      [14:0] ultra_min_freq_hz,
	output logic             ultrasonic_light_load_mode,
	output logic      [2:0]  margin_steps,
	output logic      [4:0]  fine_trim_code,
	output logic      [4:0]  fine_trim_steps,
	output logic      [16:0] vout_scale,
	output logic             target_busy
);

	pin_event_if  ev ();
	reg_access_if acc ();

	logic [2:0]     strap_sync;
	port_state_type state_r;
	port_state_type state_nxt;
	logic [2:0]     bit_cnt_r;
	logic           byte_full_r;
	logic [7:0]     shift_r;
	logic [7:0]     tx_r;
	logic [7:0]     ptr_r;
	logic           rw_r;
	logic           master_ack_r;
	logic           wr_en_r;
	logic [7:0]     wr_data_r;
	logic           sda_oe_r;
	logic           sda_oe_nxt;
	logic           receiving;
	logic           addr_match;
	logic [6:0]     own_addr;

	logic [1:0]     ultra_code_r;
	logic [14:0]    ultra_hz_r;
	logic           ultra_mode_r;
	logic [2:0]     margin_steps_r;
	logic [4:0]     trim_code_r;
	logic [4:0]     trim_steps_r;
	logic [16:0]    scale_r;

	i2c_pin_sync u_sync
	(
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.strap_in   (address_strap_pins),
		.strap_sync (strap_sync),
		.ev         (ev.producer)
	);

	reg_bank u_bank
	(
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.acc     (acc.bank)
	);

	// signed step count of the trim code, clamped to plus or minus TRIM_LIMIT (codes 04 and 1c)
	function automatic logic signed [5:0] trim_to_steps(input logic [4:0] code);
		logic signed [5:0] raw;
		raw = $signed({1'b0, code}) - $signed(`TRIM_ZERO_CODE);
		if (raw > `TRIM_LIMIT)
			return `TRIM_LIMIT;
		else if (raw < -`TRIM_LIMIT)
			return -`TRIM_LIMIT;
		else
			return raw;
	endfunction

	// margin code to signed five-percent steps; others disable
	function automatic logic signed [2:0] margin_to_steps(input logic [2:0] code);
		case (code)
			`MARGIN_DN10: return -3'sd2;
			`MARGIN_DN5:  return -3'sd1;
			`MARGIN_UP5:  return 3'sd1;
			`MARGIN_UP10: return 3'sd2;
			default:      return 3'sd0;
		endcase
	endfunction

	// only 7-bit targets: 0001 + straps, general call never matches
	assign own_addr   = {`TARGET_ADDR_HI, strap_sync};
	assign addr_match = (shift_r[7:1] == own_addr);
	assign receiving  = (state_r == ST_ADDR) || (state_r == ST_PTR)
		|| (state_r == ST_WDATA);

	// frame sequencing; transitions take effect on scl falling edges
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				state_nxt = ST_IDLE;
			ST_ADDR:
				if (byte_full_r)
					state_nxt = addr_match ? ST_ADDR_ACK : ST_IDLE;
			ST_ADDR_ACK:
				state_nxt = (rw_r == `DIR_READ) ? ST_RDATA : ST_PTR;
			ST_PTR:
				if (byte_full_r)
					state_nxt = ST_PTR_ACK;
			ST_PTR_ACK:
				state_nxt = ST_WDATA;
			ST_WDATA:
				if (byte_full_r)
					state_nxt = ST_WDATA_ACK;
			ST_WDATA_ACK:
				state_nxt = ST_IDLE;
			ST_RDATA:
				if (bit_cnt_r == 3'h7)
					state_nxt = ST_RACK;
			ST_RACK:
				state_nxt = master_ack_r ? ST_RDATA : ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// start or restart restarts addressing anywhere
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			state_r <= ST_IDLE;
		else if (ev.stop_cond)
			state_r <= ST_IDLE;
		else if (ev.start_cond)
			state_r <= ST_ADDR;
		else if (ev.scl_fall)
			state_r <= state_nxt;
	end

	// bit counter: rising edges while receiving, falling while sending
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			bit_cnt_r   <= 3'h0;
			byte_full_r <= 1'b0;
		end
		else if (ev.start_cond || ev.stop_cond)
		begin
			bit_cnt_r   <= 3'h0;
			byte_full_r <= 1'b0;
		end
		else if (ev.scl_rise && receiving)
		begin
			bit_cnt_r   <= bit_cnt_r + 3'h1;
			byte_full_r <= (bit_cnt_r == 3'h7);
		end
		else if (ev.scl_fall)
		begin
			byte_full_r <= 1'b0;
			if (state_r == ST_RDATA)
				bit_cnt_r <= bit_cnt_r + 3'h1;
		end
	end

	// msb first sampling while scl is high
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			shift_r <= 8'h00;
		else if (ev.scl_rise && receiving)
			shift_r <= {shift_r[6:0], ev.sda_level};
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			rw_r <= 1'b0;
		else if (ev.scl_fall && state_r == ST_ADDR && byte_full_r)
			rw_r <= shift_r[0];
	end

	// pointer survives stop and foreign traffic
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			ptr_r <= 8'h00;
		else if (ev.scl_fall && state_r == ST_PTR && byte_full_r)
			ptr_r <= shift_r;
	end

	// one write per transaction, to the pointed register only
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			wr_en_r   <= 1'b0;
			wr_data_r <= 8'h00;
		end
		else
		begin
			wr_en_r <= ev.scl_fall && state_r == ST_WDATA && byte_full_r;
			if (ev.scl_fall && state_r == ST_WDATA && byte_full_r)
				wr_data_r <= shift_r;
		end
	end

	// controller answer after each read byte: low means another byte
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			master_ack_r <= 1'b0;
		else if (ev.scl_rise && state_r == ST_RACK)
			master_ack_r <= ~ev.sda_level;
	end

	// repeated reads resend the same register, pointer not advanced
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			tx_r <= 8'h00;
		else if (ev.scl_fall && state_nxt == ST_RDATA && state_r != ST_RDATA)
			tx_r <= acc.rd_data;
		else if (ev.scl_fall && state_r == ST_RDATA)
			tx_r <= {tx_r[6:0], 1'b0};
	end

	// pull low for ack and for zero data bits; change only with scl low
	always_comb
	begin
		sda_oe_nxt = 1'b0;
		case (state_nxt)
			ST_ADDR_ACK,
			ST_PTR_ACK,
			ST_WDATA_ACK:
				sda_oe_nxt = byte_full_r;
			ST_RDATA:
				if (state_r == ST_RDATA)
					sda_oe_nxt = ~tx_r[6];
				else
					sda_oe_nxt = ~acc.rd_data[7];
			default:
				sda_oe_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			sda_oe_r <= 1'b0;
		else if (ev.start_cond || ev.stop_cond)
			sda_oe_r <= 1'b0;
		else if (ev.scl_fall)
			sda_oe_r <= sda_oe_nxt;
	end

	// bank read port follows the pointer; settles long before scl falls
	assign acc.rd_ptr  = ptr_r;
	assign acc.wr_ptr  = ptr_r;
	assign acc.wr_en   = wr_en_r;
	assign acc.wr_data = wr_data_r;

	// field decode, registered so outputs never glitch on writes
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ultra_code_r <= 2'h0;
			ultra_hz_r   <= `ULTRA_STEP_HZ;
			ultra_mode_r <= 1'b0;
		end
		else
		begin
			ultra_code_r <= {acc.timing_hi[`ULTRA_BIT], acc.timing_lo[`ULTRA_BIT]};
			ultra_hz_r   <= 15'(({13'h0, acc.timing_hi[`ULTRA_BIT],
				acc.timing_lo[`ULTRA_BIT]} + 15'h1) * `ULTRA_STEP_HZ);
			ultra_mode_r <= (acc.timing_hi[`PSV_MSB:0] == `PSV_ULTRASONIC);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			margin_steps_r <= 3'h0;
			trim_code_r    <= 5'h0;
			trim_steps_r   <= 5'h0;
		end
		else
		begin
			margin_steps_r <= margin_to_steps(acc.margin[`MARGIN_MSB:0]);
			trim_code_r    <= acc.fine_trim[`TRIM_MSB:0];
			trim_steps_r   <= 5'(trim_to_steps(acc.fine_trim[`TRIM_MSB:0]));
		end
	end

	// gain as product of both factors; nominal 1.0 reads as 80000
	always_ff @(posedge sys_clk)
	begin
		logic signed [10:0] fm;
		logic signed [10:0] ft;
		fm = `MARGIN_BASE + `MARGIN_UNIT * 11'(margin_to_steps(acc.margin[`MARGIN_MSB:0]));
		ft = `TRIM_BASE + `TRIM_UNIT * 11'(trim_to_steps(acc.fine_trim[`TRIM_MSB:0]));
		if (!rst_n)
			scale_r <= 17'h0;
		else
			scale_r <= 17'(22'(fm) * 22'(ft));
	end

	assign sda_out                    = 1'b0;
	assign sda_oe                     = sda_oe_r;
	assign ultra_min_freq_code        = ultra_code_r;
	assign ultra_min_freq_hz          = ultra_hz_r;
	assign ultrasonic_light_load_mode = ultra_mode_r;
	assign margin_steps               = margin_steps_r;
	assign fine_trim_code             = trim_code_r;
	assign fine_trim_steps            = trim_steps_r;
	assign vout_scale                 = scale_r;
	assign target_busy                = (state_r != ST_IDLE);

endmodule

`default_nettype wire

//--- verification/buck_ctrl_i2c_reg_port_props.sv
// assertions on the serial register port, seen from its top ports only
// assumes: bound into every instance of the port block
`timescale 1ns/100ps
`default_nettype none

module buck_ctrl_i2c_reg_port_props
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic [2:0]  address_strap_pins,
	input wire logic [1:0]  ultra_min_freq_code,
	input wire logic [14:0] ultra_min_freq_hz,
	input wire logic        ultrasonic_light_load_mode,
	input wire logic [2:0]  margin_steps,
	input wire logic [4:0]  fine_trim_code,
	input wire logic [4:0]  fine_trim_steps,
	input wire logic [16:0] vout_scale,
	input wire logic        target_busy
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	int exp_scale;
	assign exp_scale = (200 + 10 * $signed(margin_steps)) * (400 + 3 * $signed(fine_trim_steps));

	sequence idle_long;
		!target_busy [*3];
	endsequence

	sequence start_seen;
		scl_in && $fell(sda_in);
	endsequence

	open_drain_a: assert property (sda_out == 1'b0)
		else $error("sda driven high");
	busy_on_start_a: assert property (start_seen |-> ##[1:6] target_busy)
		else $error("start not taken");
	idle_quiet_a: assert property (idle_long |-> !sda_oe)
		else $error("sda pulled while idle");
	oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda changed with scl high");
	hz_from_code_a: assert property (ultra_min_freq_hz == ({13'h0, ultra_min_freq_code} + 15'h1) * 15'h186a)
		else $error("ultrasonic frequency wrong");
	trim_clamp_a: assert property ($past(rst_n) |-> fine_trim_steps == (fine_trim_code < 5'h04 ? 5'h14 :
		fine_trim_code > 5'h1b ? 5'h0c : fine_trim_code ^ 5'h10))
		else $error("trim steps wrong");
	margin_range_a: assert property (margin_steps inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7})
		else $error("margin steps out of range");
	scale_product_a: assert property ($past(rst_n) |-> vout_scale == exp_scale[16:0])
		else $error("scale not a product");
	fields_hold_a: assert property (idle_long |=> $stable(fine_trim_code) && $stable(margin_steps)
		&& $stable(ultra_min_freq_code))
		else $error("field moved while idle");
endmodule

bind buck_ctrl_i2c_reg_port buck_ctrl_i2c_reg_port_props buck_ctrl_i2c_reg_port_props_i
(
	.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .address_strap_pins(address_strap_pins),
	.ultra_min_freq_code(ultra_min_freq_code), .ultra_min_freq_hz(ultra_min_freq_hz),
	.ultrasonic_light_load_mode(ultrasonic_light_load_mode), .margin_steps(margin_steps),
	.fine_trim_code(fine_trim_code), .fine_trim_steps(fine_trim_steps),
	.vout_scale(vout_scale), .target_busy(target_busy)
);

`default_nettype wire

//--- verification/i2c_ctrl_model.sv
// bus controller model: drives scl, pulls sda low, samples the wire
// assumes: bench resolves sda as a pulled-up wire
`timescale 1ns/100ps
`default_nettype none

module i2c_ctrl_model
(
	input  wire logic sys_clk,
	input  wire logic sda,
	output var logic  scl,
	output var logic  sda_pull
);
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// 25 clocks a quarter bit: 400 kbit/s, the fastest allowed
	task automatic quarter();
		repeat (25) @(negedge sys_clk);
	endtask

	// also a repeated start when scl is low
	task automatic start();
		sda_pull = 1'b0;
		quarter();
		scl = 1'b1;
		quarter();
		sda_pull = 1'b1;
		quarter();
		scl = 1'b0;
		quarter();
	endtask

	task automatic stop();
		sda_pull = 1'b1;
		quarter();
		scl = 1'b1;
		quarter();
		sda_pull = 1'b0;
		quarter();
	endtask

	// nine bits msb first; a one releases the line for the target
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
		begin
			sda_pull = !d[i];
			quarter();
			scl = 1'b1;
			quarter();
			r[i] = sda;
			quarter();
			scl = 1'b0;
			quarter();
		end
	endtask
endmodule

`default_nettype wire

//--- verification/tb_buck_ctrl_i2c_reg_port.sv
// self-checking bench for the serial register port
// assumes: sda pulled up, controller model owns scl, straps 5 then 2
`timescale 1ns/100ps
`default_nettype none

module tb_buck_ctrl_i2c_reg_port;
	logic        sys_clk;
	logic        rst_n;
	logic        scl;
	logic        sda_pull;
	logic        sda_out;
	logic        sda_oe;
	logic        target_busy;
	logic [1:0]  ultra_min_freq_code;
	logic [14:0] ultra_min_freq_hz;
	logic        ultrasonic_light_load_mode;
	logic [2:0]  margin_steps;
	logic [4:0]  fine_trim_code;
	logic [4:0]  fine_trim_steps;
	logic [16:0] vout_scale;
	logic [8:0]  r;
	logic [6:0]  dev;
	logic [2:0]  straps;
	int          mismatches;
	int          checks;
	wire         sda = !sda_pull && !(sda_oe && !sda_out);

	assign dev = {4'h1, straps};

	buck_ctrl_i2c_reg_port buck_ctrl_i2c_reg_port_i
	(
		.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .address_strap_pins(straps), .ultra_min_freq_code(ultra_min_freq_code),
		.ultra_min_freq_hz(ultra_min_freq_hz), .margin_steps(margin_steps),
		.ultrasonic_light_load_mode(ultrasonic_light_load_mode), .vout_scale(vout_scale),
		.fine_trim_code(fine_trim_code), .fine_trim_steps(fine_trim_steps),
		.target_busy(target_busy)
	);

	i2c_ctrl_model i2c_ctrl_model_i
	(
		.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = !sys_clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// byte out, answer bit in: 0 is an acknowledge
	task automatic put(input logic [7:0] b, input logic nak);
		i2c_ctrl_model_i.xfer({b, 1'b1}, r);
		check("ack", r[0], nak);
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		i2c_ctrl_model_i.start();
		put({dev, 1'b0}, 1'b0);
		put(p, 1'b0);
		put(d, 1'b0);
		i2c_ctrl_model_i.stop();
	endtask

	// (re)start, read address, one byte closed by nack and stop
	task automatic get(input logic [7:0] e);
		i2c_ctrl_model_i.start();
		put({dev, 1'b1}, 1'b0);
		i2c_ctrl_model_i.xfer(9'h1ff, r);
		check("data", r[8:1], e);
		i2c_ctrl_model_i.stop();
	endtask

	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		i2c_ctrl_model_i.start();
		put({dev, 1'b0}, 1'b0);
		put(p, 1'b0);
		get(e);
	endtask

	task automatic regs_rw();
		rd(8'h02, 8'h00);
		wr(8'h00, 8'h5a);
		wr(8'h01, 8'ha5);
		rd(8'h00, 8'h5a);
	endtask

	task automatic ultra();
		wr(8'h02, 8'h20);
		check("uf", {ultra_min_freq_code, ultra_min_freq_hz}, {2'h1, 15'h30d4});
		wr(8'h03, 8'h22);
		check("uf", {ultra_min_freq_code, ultra_min_freq_hz}, {2'h3, 15'h61a8});
		check("mode", ultrasonic_light_load_mode, 1'b1);
		wr(8'h02, 8'h00);
		check("uf", {ultra_min_freq_code, ultra_min_freq_hz}, {2'h2, 15'h493e});
	endtask

	task automatic margin();
		logic [2:0] e [8] = '{3'h0, 3'h6, 3'h7, 3'h0, 3'h0, 3'h1, 3'h2, 3'h0};
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h06, 8'(c));
			check("margin", margin_steps, e[c]);
		end
	endtask

	task automatic trim();
		logic [4:0] c [5] = '{5'h00, 5'h04, 5'h10, 5'h1b, 5'h1c};
		logic [4:0] e [5] = '{5'h14, 5'h14, 5'h00, 5'h0b, 5'h0c};
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h04, {3'h0, c[i]});
			check("trim", {fine_trim_code, fine_trim_steps}, {c[i], e[i]});
		end
		wr(8'h06, 8'h06);
		wr(8'h04, 8'h1f);
		check("scale", vout_scale, 17'h176b0);
		wr(8'h04, 8'h00);
		check("scale", vout_scale, 17'h138d0);
	endtask

	// pointer set, traffic to a neighbour target, read much later
	task automatic sep_read();
		i2c_ctrl_model_i.start();
		put({dev, 1'b0}, 1'b0);
		put(8'h06, 1'b0);
		i2c_ctrl_model_i.stop();
		i2c_ctrl_model_i.start();
		put({4'h1, 3'h2, 1'b0}, 1'b1);
		i2c_ctrl_model_i.stop();
		get(8'h06);
	endtask

	task automatic odd_cases();
		i2c_ctrl_model_i.start();
		put(8'hf0, 1'b1);
		i2c_ctrl_model_i.stop();
		// bus idle here, so the strap move cannot split a frame
		straps = 3'h2;
		wr(8'h05, 8'h3c);
		rd(8'h05, 8'h00);
		i2c_ctrl_model_i.start();
		put({dev, 1'b0}, 1'b0);
		put(8'h02, 1'b0);
		put(8'h11, 1'b0);
		put(8'h77, 1'b1);
		i2c_ctrl_model_i.start();
		put({dev, 1'b0}, 1'b0);
		put(8'h01, 1'b0);
		put(8'h99, 1'b0);
		i2c_ctrl_model_i.stop();
		rd(8'h02, 8'h11);
		rd(8'h01, 8'h99);
		rd(8'h03, 8'h22);
	endtask

	initial
	begin
		rst_n = 1'b0;
		straps = 3'h5;
		mismatches = 0;
		checks = 0;
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		check("hz", ultra_min_freq_hz, 15'h186a);
		// trim register resets to code 00, the low end code
		check("scale", vout_scale, 17'h11c60);
		regs_rw();
		ultra();
		margin();
		trim();
		sep_read();
		odd_cases();
		conclude();
	end

	// the sequence needs about 99200 clocks
	initial
	begin
		repeat (105000) @(posedge sys_clk);
		mismatches++;
		conclude();
	end
endmodule

`default_nettype wire
